// [design/irps_shaper.sv]
// Purpose: Infrared pulse shaper between the second UART and its pins.
// Assumes: All inputs are synchronous to I_REF_CLK; UART runs one rate for both directions.
// Notes: Both pin paths are registered, so bypass adds one clock of latency.
// Behaviour
// - Setting the enable bit routes transmit and receive through the shaper and detaches the UART.
// - The pulse-mode bit picks a fixed-width pulse when zero and a 3/16 bit-time pulse when one.
// - In proportional mode each data pulse lasts three sixteenths of the selected bit period.
// - In fixed mode each pulse has the same width at every baud rate, ideally 1.63 us.
// - The reference clock is the oscillator divided by the five-bit divider field in bits 4 to 0.
// - After reset the control register reads 0Fh, so enable and pulse mode are clear.
// - The baud field in bits 7 to 4 gives the UART rate, from code 0 at 115.2k to 12 at 1.2k.
// - While disabled the UART signals pass straight to and from the pins.
// - Each zero bit of the UART frame becomes a high pulse and each one bit gives no pulse.
// - Each short pulse on the receive pin is stretched into a full-bit zero for the UART.
`timescale 1ns/1ns
`default_nettype none
module irps_shaper #(
    parameter int P_CLK_HZ = irps_pkg::CLK_HZ
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic I_UART_TXD,
    input wire logic I_UART_RX_PIN,
    output logic [7:0] O_SFR_RDATA,
    output logic O_UART_TX_PIN,
    output logic O_UART_RXD
);
    irps_pkg::irps_ctrl_t ctrl_r, ctrl_nxt;
    logic [3:0] baud_r, baud_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    irps_pkg::irps_tx_st_t st_r, st_nxt;
    logic [irps_pkg::CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
    logic [irps_pkg::CNT_W-1:0] pcnt_r, pcnt_nxt;
    logic [irps_pkg::CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
    logic [4:0] div_cnt_r, div_cnt_nxt;
    logic txd_prev_r, rxp_prev_r;
    logic tx_pin_r, tx_pin_nxt, rxd_r, rxd_nxt;
    logic [irps_pkg::CNT_W-1:0] bit_cyc, prop_cyc;
    logic [4:0] divisor;
    logic bit_start, start, ref_tick, pulse_end;

    // Bit and proportional pulse lengths follow the baud code; the shaper cannot see the UART timers.
    always_comb begin
        bit_cyc = irps_pkg::CNT_W'(P_CLK_HZ / irps_pkg::rate_bps(baud_r));
        prop_cyc = irps_pkg::CNT_W'((irps_pkg::PROP_NUM * (P_CLK_HZ / irps_pkg::PROP_DEN))
                   / irps_pkg::rate_bps(baud_r));
        // A zero divider would stall the reference clock, so it is treated as one.
        divisor = (ctrl_r.div < irps_pkg::DIV_MIN) ? irps_pkg::DIV_MIN : ctrl_r.div;
    end

    // Register port.
    always_comb begin
        ctrl_nxt = ctrl_r;
        baud_nxt = baud_r;
        rdata_nxt = 8'h00;
        if (I_SFR_WR && I_SFR_ADDR == irps_pkg::ADDR_CTRL) begin
            ctrl_nxt.en = I_SFR_WDATA[irps_pkg::EN_BIT];
            ctrl_nxt.pulse_mode = I_SFR_WDATA[irps_pkg::MODE_BIT];
            ctrl_nxt.div = I_SFR_WDATA[irps_pkg::DIV_MSB:0];
        end
        if (I_SFR_WR && I_SFR_ADDR == irps_pkg::ADDR_BAUD) begin
            baud_nxt = I_SFR_WDATA[irps_pkg::BR_MSB:irps_pkg::BR_LSB];
        end
        if (I_SFR_ADDR == irps_pkg::ADDR_CTRL) begin
            rdata_nxt = {1'b0, ctrl_r};
        end else if (I_SFR_ADDR == irps_pkg::ADDR_BAUD) begin
            rdata_nxt = {baud_r, 4'h0};
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_r <= irps_pkg::irps_ctrl_t'(irps_pkg::CTRL_RESET[6:0]);
            baud_r <= irps_pkg::BAUD_RESET[irps_pkg::BR_MSB:irps_pkg::BR_LSB];
            rdata_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            baud_r <= baud_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Transmit path. The bit timer realigns on every falling UART edge so that
    // drift between our baud figure and the UART's real rate never accumulates.
    always_comb begin
        bit_start = (txd_prev_r && !I_UART_TXD) || (bit_cnt_r == bit_cyc - 1'b1);
        bit_cnt_nxt = bit_start ? '0 : bit_cnt_r + 1'b1;
        start = ctrl_r.en && (st_r == irps_pkg::S_IDLE) && bit_start && !I_UART_TXD;
        // Restarting the prescaler at the pulse start makes the fixed width exact.
        ref_tick = !start && (div_cnt_r == divisor - 1'b1);
        div_cnt_nxt = (start || ref_tick) ? 5'h00 : div_cnt_r + 1'b1;
        if (ctrl_r.pulse_mode) begin
            pulse_end = (pcnt_r == prop_cyc - 1'b1);
        end else begin
            pulse_end = ref_tick
                && (pcnt_r == irps_pkg::CNT_W'(irps_pkg::FIXED_REF_TICKS - 1));
        end
        st_nxt = st_r;
        pcnt_nxt = pcnt_r;
        case (st_r)
            irps_pkg::S_IDLE: begin
                if (start) begin
                    st_nxt = irps_pkg::S_PULSE;
                    pcnt_nxt = '0;
                end
            end
            irps_pkg::S_PULSE: begin
                if (!ctrl_r.en || pulse_end) begin
                    st_nxt = irps_pkg::S_IDLE;
                end else if (ctrl_r.pulse_mode || ref_tick) begin
                    pcnt_nxt = pcnt_r + 1'b1;
                end
            end
            default: st_nxt = irps_pkg::S_IDLE;
        endcase
        tx_pin_nxt = ctrl_r.en ? (st_nxt == irps_pkg::S_PULSE) : I_UART_TXD;
    end

    // Receive path. A new pulse restarts the stretch, so back-to-back zeros merge.
    always_comb begin
        rx_cnt_nxt = (rx_cnt_r != '0) ? rx_cnt_r - 1'b1 : '0;
        if (ctrl_r.en && I_UART_RX_PIN && !rxp_prev_r) begin
            rx_cnt_nxt = bit_cyc;
        end
        rxd_nxt = ctrl_r.en ? (rx_cnt_nxt == '0) : I_UART_RX_PIN;
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            st_r <= irps_pkg::S_IDLE;
            bit_cnt_r <= '0;
            pcnt_r <= '0;
            rx_cnt_r <= '0;
            div_cnt_r <= 5'h00;
            txd_prev_r <= 1'b1;
            rxp_prev_r <= 1'b0;
            tx_pin_r <= 1'b1;
            rxd_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            pcnt_r <= pcnt_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            div_cnt_r <= div_cnt_nxt;
            txd_prev_r <= I_UART_TXD;
            rxp_prev_r <= I_UART_RX_PIN;
            tx_pin_r <= tx_pin_nxt;
            rxd_r <= rxd_nxt;
        end
    end

    assign O_SFR_RDATA = rdata_r;
    assign O_UART_TX_PIN = tx_pin_r;
    assign O_UART_RXD = rxd_r;

    // Helper counters seen only by the checks below.
    logic [irps_pkg::CNT_W-1:0] len_r;
    logic [1:0] ticks_r;
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            len_r <= '0;
            ticks_r <= 2'h0;
        end else begin
            len_r <= (st_r == irps_pkg::S_PULSE) ? len_r + 1'b1 : '0;
            ticks_r <= (st_r != irps_pkg::S_PULSE) ? 2'h0 : ticks_r + 2'(ref_tick);
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    property p_reset_value;
        $fell(I_RST) |-> ctrl_r == irps_pkg::CTRL_RESET[6:0] && O_UART_RXD && O_UART_TX_PIN;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("Control register or pins wrong after reset.");

    property p_ctrl_write;
        I_SFR_WR && I_SFR_ADDR == irps_pkg::ADDR_CTRL |=> ctrl_r == $past(I_SFR_WDATA[6:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Control write not stored.");

    property p_baud_write;
        I_SFR_WR && I_SFR_ADDR == irps_pkg::ADDR_BAUD |=> baud_r == $past(I_SFR_WDATA[7:4]);
    endproperty
    a_baud_write: assert property (p_baud_write) else $error("Baud field not stored.");

    property p_bypass_tx;
        !ctrl_r.en |=> O_UART_TX_PIN == $past(I_UART_TXD);
    endproperty
    a_bypass_tx: assert property (p_bypass_tx) else $error("Transmit bypass broken.");

    property p_bypass_rx;
        !ctrl_r.en |=> O_UART_RXD == $past(I_UART_RX_PIN);
    endproperty
    a_bypass_rx: assert property (p_bypass_rx) else $error("Receive bypass broken.");

    property p_zero_pulses;
        start |=> O_UART_TX_PIN && st_r == irps_pkg::S_PULSE;
    endproperty
    a_zero_pulses: assert property (p_zero_pulses) else $error("Zero bit gave no pulse.");

    property p_idle_low;
        ctrl_r.en && st_r == irps_pkg::S_IDLE && !start |=> !O_UART_TX_PIN;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("Pin high with no pulse.");

    property p_prop_len;
        st_r == irps_pkg::S_PULSE && st_nxt == irps_pkg::S_IDLE && ctrl_r.en && ctrl_r.pulse_mode
            |-> len_r + 1'b1 == prop_cyc;
    endproperty
    a_prop_len: assert property (p_prop_len)
        else $error("Proportional pulse length wrong.");

    property p_fixed_len;
        st_r == irps_pkg::S_PULSE && st_nxt == irps_pkg::S_IDLE && ctrl_r.en && !ctrl_r.pulse_mode
            |-> ticks_r == 2'(irps_pkg::FIXED_REF_TICKS - 1) && ref_tick;
    endproperty
    a_fixed_len: assert property (p_fixed_len)
        else $error("Fixed pulse not three ticks.");

    property p_rx_stretch;
        ctrl_r.en && I_UART_RX_PIN && !rxp_prev_r ##1 ctrl_r.en |-> !O_UART_RXD ##1 !O_UART_RXD;
    endproperty
    a_rx_stretch: assert property (p_rx_stretch)
        else $error("Receive pulse not stretched.");

    c_prop_pulse: cover property (start && ctrl_r.pulse_mode ##1 st_r == irps_pkg::S_PULSE);
    c_fixed_pulse: cover property (start && !ctrl_r.pulse_mode ##1 st_r == irps_pkg::S_PULSE);
    c_rx_pulse: cover property (ctrl_r.en && $rose(I_UART_RX_PIN));
    c_bypass: cover property (!ctrl_r.en && $fell(I_UART_TXD));
endmodule // irps_shaper
`default_nettype wire

// [design/irps_pkg.sv]
// Purpose: Shared constants and types for the infrared pulse shaper.
// Assumes: Oscillator clock of 100 MHz on the shaper clock input.
// Notes: Register addresses are byte addresses on the special function register port.
package irps_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'hCE;
    localparam logic [7:0] ADDR_BAUD = 8'hCF;
    localparam logic [7:0] CTRL_RESET = 8'h0F;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam int EN_BIT = 6;
    localparam int MODE_BIT = 5;
    localparam int DIV_MSB = 4;
    localparam int BR_MSB = 7;
    localparam int BR_LSB = 4;
    localparam int CLK_HZ = 100_000_000;
    localparam int CNT_W = 20;
    localparam int FIXED_REF_TICKS = 3;
    localparam int PROP_NUM = 3;
    localparam int PROP_DEN = 16;
    localparam logic [4:0] DIV_MIN = 5'h01;

    typedef struct packed {
        logic en;
        logic pulse_mode;
        logic [4:0] div;
    } irps_ctrl_t;

    typedef enum logic {S_IDLE, S_PULSE} irps_tx_st_t;

    function automatic int rate_bps(input logic [3:0] code);
        case (code)
            4'h0: rate_bps = 115_200;
            4'h1: rate_bps = 57_500;
            4'h2: rate_bps = 38_400;
            4'h3: rate_bps = 19_200;
            4'h4: rate_bps = 14_400;
            4'h5: rate_bps = 12_800;
            4'h6: rate_bps = 9_600;
            4'h7: rate_bps = 7_200;
            4'h8: rate_bps = 4_800;
            4'h9: rate_bps = 3_600;
            4'hA: rate_bps = 2_400;
            4'hB: rate_bps = 1_800;
            default: rate_bps = 1_200;
        endcase
    endfunction
endpackage

// [dv/irps_xcvr_model.sv]
// Purpose: Behavioural infrared transceiver facing the shaper pins.
// Assumes: Both optical wires are active high and idle low.
// Notes: Widths are counted in shaper clock cycles.
`timescale 1ns/1ns
`default_nettype none
module irps_xcvr_model (
    input wire logic i_clk,
    input wire logic i_tx_pin,
    input wire logic i_send,
    input wire logic [7:0] i_width,
    output logic o_rx_pin,
    output int o_last_width,
    output int o_pulse_count
);
    int run = 0;
    int left = 0;
    logic rx_q = 1'b0;
    int last_q = 0;
    int count_q = 0;
    assign o_rx_pin = rx_q;
    assign o_last_width = last_q;
    assign o_pulse_count = count_q;
    // Everything moves on the rising edge with non-blocking updates, so the shaper never races us.
    always @(posedge i_clk) begin
        if (i_tx_pin === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_q <= run;
            count_q <= count_q + 1;
            run <= 0;
        end
        if (left != 0) begin
            rx_q <= 1'b1;
            left <= left - 1;
        end else begin
            rx_q <= 1'b0;
            if (i_send) begin
                left <= int'(i_width);
            end
        end
    end
endmodule // irps_xcvr_model
`default_nettype wire

// [dv/irps_shaper_bench.sv]
// Purpose: Self-checking bench for the infrared pulse shaper.
// Assumes: Shortened clock parameter so one bit at code 0 is 16 cycles.
// Notes: Pulse widths are measured by the transceiver model.
`timescale 1ns/1ns
`default_nettype none
module irps_shaper_bench;
    logic clk, rst, sfr_wr, uart_txd, rx_pin, tx_pin, rxd, send;
    logic [7:0] sfr_addr, sfr_wdata, rdata, got;
    int num_errors, check_count, last_w, pcount, base, lows;
    logic [7:0] ctrl_tab [5] = '{8'h64, 8'h64, 8'h44, 8'h44, 8'h45};
    logic [7:0] baud_tab [5] = '{8'h00, 8'h60, 8'h00, 8'h60, 8'h60};
    int bit_tab [5] = '{16, 192, 16, 192, 192};
    int wid_tab [5] = '{3, 36, 12, 12, 15};
    irps_shaper #(.P_CLK_HZ(1_843_200)) i_irps_shaper (.I_REF_CLK(clk), .I_RST(rst),
        .I_SFR_ADDR(sfr_addr), .I_SFR_WR(sfr_wr), .I_SFR_WDATA(sfr_wdata),
        .I_UART_TXD(uart_txd), .I_UART_RX_PIN(rx_pin), .O_SFR_RDATA(rdata),
        .O_UART_TX_PIN(tx_pin), .O_UART_RXD(rxd));
    irps_xcvr_model i_irps_xcvr_model (.i_clk(clk), .i_tx_pin(tx_pin), .i_send(send),
        .i_width(8'h03), .o_rx_pin(rx_pin), .o_last_width(last_w), .o_pulse_count(pcount));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic check_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_len(input string n, input int e, input int g);
        check_count++;
        if (g != e) begin
            num_errors++;
            $display("unexpected %s expected %0d seen %0d", n, e, g);
        end
    endtask
    // A zero bit is held low for a whole bit time; the frame is start, eight bits, stop.
    task automatic send_frame(input logic [7:0] b, input int bitc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            uart_txd = f[i];
            tick(bitc - 1);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        num_errors = 0;
        check_count = 0;
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        uart_txd = 1'b1;
        send = 1'b0;
        tick(12);
        rst = 1'b0;
        rd(8'hCE, got);
        check_reg("ctrl reset", 8'h0F, got);
        rd(8'hCF, got);
        check_reg("baud reset", 8'h00, got);
        rd(8'hCD, got);
        check_reg("unmapped", 8'h00, got);
        wr(8'hCE, 8'hFF);
        rd(8'hCE, got);
        check_reg("ctrl rw", 8'h7F, got);
        wr(8'hCF, 8'hFF);
        rd(8'hCF, got);
        check_reg("baud rw", 8'hF0, got);
        wr(8'h10, 8'hAA);
        rd(8'hCE, got);
        check_reg("ctrl kept", 8'h7F, got);
        $display("test registers done");
        wr(8'hCE, 8'h0F);
        uart_txd = 1'b0;
        tick(2);
        check_reg("bypass tx low", 8'h00, {7'h00, tx_pin});
        uart_txd = 1'b1;
        tick(2);
        check_reg("bypass tx high", 8'h01, {7'h00, tx_pin});
        check_reg("bypass rx low", 8'h00, {7'h00, rxd});
        // A short pin pulse must come through unstretched while the shaper is off.
        send = 1'b1;
        @(negedge clk);
        send = 1'b0;
        tick(2);
        check_reg("bypass rx high", 8'h01, {7'h00, rxd});
        $display("test bypass done");
        // The divider stays at four or above whenever fixed mode is selected.
        for (int k = 0; k < 5; k++) begin
            wr(8'hCE, ctrl_tab[k]);
            wr(8'hCF, baud_tab[k]);
            base = pcount;
            send_frame(8'h35, bit_tab[k]);
            tick(4);
            check_len("pulse count", 5, pcount - base);
            check_len("pulse width", wid_tab[k], last_w);
        end
        $display("test transmit done");
        for (int k = 0; k < 2; k++) begin
            wr(8'hCE, 8'h64);
            wr(8'hCF, baud_tab[k]);
            send = 1'b1;
            @(negedge clk);
            send = 1'b0;
            lows = 0;
            for (int n = 0; n < 10 && rxd !== 1'b0; n++) @(negedge clk);
            if (rxd !== 1'b0) begin
                num_errors++;
                $display("unexpected rx stretch expected 0 seen 1");
                test_done();
            end
            while (rxd === 1'b0 && lows < 400) begin
                @(negedge clk);
                lows++;
            end
            check_len("rx low", bit_tab[k], lows);
        end
        $display("test receive done");
        test_done();
    end
endmodule // irps_shaper_bench
`default_nettype wire
